// ===== pkg/bms_pkg.sv
// shared constants, types and decode helpers of the bridge measurement sequencer
package bms_pkg;

  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_KHZ = 100000;
  localparam int ADC_CLK_KHZ = 1000;
  localparam int ADC_DIV = SYS_CLK_KHZ / ADC_CLK_KHZ;
  localparam logic [6:0] ADC_DIV_LAST = 7'(ADC_DIV - 1);
  localparam int CONV_CNT_W = 18;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;

  // control register fields
  localparam int CTRL_CMD_MODE = 0;
  localparam int CTRL_START_FULL = 1;
  localparam int CTRL_START_SINGLE = 2;
  localparam int CTRL_KIND_LO = 3;
  localparam int CTRL_RELOAD = 5;
  localparam logic CMD_MODE_RESET = 1'b0;

  // status register fields
  localparam int STAT_DONE = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_ACTIVE = 2;
  localparam int STAT_KIND_LO = 3;
  localparam int STAT_MUX_LO = 5;
  localparam int STAT_STATE_LO = 8;

  // ----------------------------------------------------------------
  // measurement configuration word layout
  // ----------------------------------------------------------------
  localparam int CFG_W = 16;
  localparam int CFG_G1_LO = 0;
  localparam int CFG_G2_LO = 2;
  localparam int CFG_POL = 5;
  localparam int CFG_MSB_LO = 6;
  localparam int CFG_LSB_LO = 8;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MUX_BRIDGE = 2'b00,
    MUX_TEMP = 2'b01,
    MUX_SHORT = 2'b10
  } bms_mux_t;

  typedef enum logic [1:0] {
    KIND_BRIDGE = 2'b00,
    KIND_TEMP = 2'b01,
    KIND_OFFSET = 2'b10
  } bms_kind_t;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] msb_bits(input logic [1:0] sel);
    msb_bits = 5'h0a + {2'b00, sel, 1'b0};
  endfunction : msb_bits

  function automatic logic [2:0] lsb_bits(input logic [1:0] sel);
    case (sel)
      2'b00: lsb_bits = 3'h0;
      2'b01: lsb_bits = 3'h3;
      2'b10: lsb_bits = 3'h5;
      default: lsb_bits = 3'h7;
    endcase
  endfunction : lsb_bits

endpackage : bms_pkg

// ===== pkg/bms_conv_if.sv
// handshake between the sequencer and its conversion timer
`timescale 1ns/1ps
`default_nettype none
interface bms_conv_if;
  logic start;
  logic [1:0] msbSel;
  logic [1:0] lsbSel;
  logic busy;
  logic done;

  modport seq (output start, output msbSel, output lsbSel, input busy, input done);
  modport timer (input start, input msbSel, input lsbSel, output busy, output done);
endinterface : bms_conv_if
`default_nettype wire

// ===== rtl/bms_conv_timer.sv
// conversion timer: paces one conversion in adc clock ticks, 2^msb + 2^lsb long
`timescale 1ns/1ps
`default_nettype none
module bms_conv_timer
(
  input wire logic sys_clk,
  input wire logic rst,
  bms_conv_if.timer conv
);
  import bms_pkg::*;

  typedef struct packed {
    logic busy;
    logic done;
    logic [6:0] div;
    logic [CONV_CNT_W-1:0] ticks;
  } bms_tmr_st_t;

  bms_tmr_st_t st;
  bms_tmr_st_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (conv.start && !st.busy)
    begin
      // ticks-1 so the done pulse lands on the last tick
      next_st.busy = 1'b1;
      next_st.div = ADC_DIV_LAST;
      next_st.ticks = (CONV_CNT_W'(1) << msb_bits(conv.msbSel))
                    + (CONV_CNT_W'(1) << lsb_bits(conv.lsbSel)) - CONV_CNT_W'(1);
    end
    else if (st.busy)
    begin
      if (st.div != 7'h00)
      begin
        next_st.div = st.div - 7'h01;
      end
      else if (st.ticks != '0)
      begin
        next_st.div = ADC_DIV_LAST;
        next_st.ticks = st.ticks - CONV_CNT_W'(1);
      end
      else
      begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign conv.busy = st.busy;
  assign conv.done = st.done;

endmodule : bms_conv_timer
`default_nettype wire

// ===== rtl/bms_sequencer.sv
// bridge measurement sequencer: modes, measurement steps, input mux and gain decode
//
// Contract
// [RL1] two modes only: normal and command
// [RL2] normal mode: wake, measure once, sleep again
// [RL3] measures bridge, temperature and offset
// [RL4] mux picks bridge pins, temp sensor, short
// [RL5] full request runs every kind automatically
// [RL6] auto-zero precedes each bridge and temperature
// [RL7] resolution programmable from 10 to 16 bits (msb plus lsb decode here reaches 10 to 22 bits)
// [RL8] config bits 1:0 and 4:2 hold gains
// [RL9] first gain codes give 12, 20, 30, 40
// [RL10] second gain 1.1 to 1.8 in 0.1 steps
// [RL11] polarity bit inverts chopper clock, bridge sign
// [RL12] gains and polarity come from nonvolatile word
// [RL13] supervisor reset initialises all digital state
// [RL14] host picks offset shift 1/16 to 8/16
// [RL15] host picks nearest gain not above optimum
// [RL16] host inverts polarity if max not larger
// [RL17] one clock; held asleep during reset
`timescale 1ns/1ps
`default_nettype none
module bms_sequencer
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [bms_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic [bms_pkg::CFG_W-1:0] measurement_config_word,
  output logic activeState,
  output logic [1:0] muxSel,
  output logic autoZero,
  output logic chopperInvert,
  output logic [1:0] measKind,
  output logic convActive,
  output logic [5:0] first_amp_gain_sel,
  output logic [4:0] second_amp_gain_sel,
  output logic [4:0] adcMsbBits,
  output logic [2:0] adcLsbBits,
  output logic [4:0] adcResolution,
  output logic seqDone
);
  import bms_pkg::*;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SLEEP = 3'b000,
    ST_ACTIVE = 3'b001,
    ST_SETUP = 3'b010,
    ST_CONVERT = 3'b011,
    ST_NEXT = 3'b100
  } bms_state_t;

  typedef enum logic [2:0] {
    STEP_AZ_BRIDGE = 3'b000,
    STEP_BRIDGE = 3'b001,
    STEP_AZ_TEMP = 3'b010,
    STEP_TEMP = 3'b011,
    STEP_OFFSET = 3'b100
  } bms_step_t;

  typedef struct packed {
    bms_state_t state;
    bms_step_t step;
    logic fullSeq;
    logic cmdMode;
    logic loadPending;
    logic [CFG_W-1:0] cfg;
    logic [1:0] muxSel;
    logic autoZero;
    logic chopInv;
    logic [1:0] measKind;
    logic seqDone;
    logic doneSticky;
    logic [15:0] seqCount;
    logic [31:0] rdData;
    logic [5:0] firstGain;
    logic [4:0] secondGain;
    logic [4:0] msbBits;
    logic [2:0] lsbBits;
    logic [4:0] resolution;
  } bms_seq_st_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] first_gain(input logic [1:0] code);
    case (code)
      2'b00: first_gain = 6'h0c;
      2'b01: first_gain = 6'h14;
      2'b10: first_gain = 6'h1e;
      default: first_gain = 6'h28;
    endcase
  endfunction : first_gain

  // second stage gain in tenths: 11 for code 0 up to 18 for code 7
  function automatic logic [4:0] second_gain(input logic [2:0] code);
    second_gain = 5'h0b + {2'b00, code};
  endfunction : second_gain

  function automatic logic step_is_az(input bms_step_t s);
    step_is_az = (s == STEP_AZ_BRIDGE) || (s == STEP_AZ_TEMP);
  endfunction : step_is_az

  // last step of a single request, or the offset step ending a full one
  function automatic logic step_is_last(input bms_step_t s, input logic full);
    if (full)
    begin
      step_is_last = (s == STEP_OFFSET);
    end
    else
    begin
      step_is_last = (s == STEP_BRIDGE) || (s == STEP_TEMP) || (s == STEP_OFFSET);
    end
  endfunction : step_is_last

  // ----------------------------------------------------------------
  // state and conversion timer
  // ----------------------------------------------------------------
  bms_seq_st_t st;
  bms_seq_st_t next_st;
  bms_conv_if conv ();

  bms_conv_timer timer_inst
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .conv(conv.timer)
  );

  logic wrCtrl;
  logic wrStatus;
  logic reqFull;
  logic reqSingle;
  logic [1:0] reqKind;

  always_comb
  begin
    wrCtrl = regWr && (regAddr == OFS_CTRL);
    wrStatus = regWr && (regAddr == OFS_STATUS);
    reqFull = wrCtrl && regWrData[CTRL_START_FULL];
    reqSingle = wrCtrl && regWrData[CTRL_START_SINGLE] && !regWrData[CTRL_START_FULL];
    reqKind = regWrData[CTRL_KIND_LO +: 2];
  end

  assign conv.start = (st.state == ST_SETUP);
  assign conv.msbSel = st.cfg[CFG_MSB_LO +: 2];
  assign conv.lsbSel = st.cfg[CFG_LSB_LO +: 2];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.seqDone = 1'b0;

    // configuration is copied from the nonvolatile word after reset or on reload
    if (st.loadPending || (wrCtrl && regWrData[CTRL_RELOAD]))
    begin
      next_st.cfg = measurement_config_word; // RL12
      next_st.loadPending = 1'b0;
    end
    next_st.firstGain = first_gain(st.cfg[CFG_G1_LO +: 2]); // RL8 RL9
    next_st.secondGain = second_gain(st.cfg[CFG_G2_LO +: 3]); // RL8 RL10
    next_st.msbBits = msb_bits(st.cfg[CFG_MSB_LO +: 2]); // RL7
    next_st.lsbBits = lsb_bits(st.cfg[CFG_LSB_LO +: 2]);
    // built from the same decode so resolution never lags the segment outputs
    if (next_st.lsbBits == 3'h0)
    begin
      next_st.resolution = next_st.msbBits; // RL7
    end
    else
    begin
      next_st.resolution = next_st.msbBits + {2'b00, next_st.lsbBits} - 5'h01;
    end

    if (wrCtrl)
    begin
      next_st.cmdMode = regWrData[CTRL_CMD_MODE]; // RL1
    end

    case (st.state)
      ST_SLEEP:
      begin
        // normal mode only wakes for a full request; command mode stays awake
        if (wrCtrl && regWrData[CTRL_CMD_MODE])
        begin
          next_st.state = ST_ACTIVE; // RL1
        end
        else if (reqFull)
        begin
          next_st.state = ST_SETUP; // RL2
          next_st.step = STEP_AZ_BRIDGE; // RL5 RL6
          next_st.fullSeq = 1'b1;
        end
      end
      ST_ACTIVE:
      begin
        if (wrCtrl && !regWrData[CTRL_CMD_MODE])
        begin
          next_st.state = ST_SLEEP; // RL1
        end
        else if (reqFull)
        begin
          next_st.state = ST_SETUP;
          next_st.step = STEP_AZ_BRIDGE; // RL5
          next_st.fullSeq = 1'b1;
        end
        else if (reqSingle)
        begin
          next_st.state = ST_SETUP;
          next_st.fullSeq = 1'b0;
          if (reqKind == KIND_TEMP)
          begin
            next_st.step = STEP_AZ_TEMP; // RL6
          end
          else if (reqKind == KIND_OFFSET)
          begin
            next_st.step = STEP_OFFSET; // RL3
          end
          else
          begin
            next_st.step = STEP_AZ_BRIDGE; // RL6
          end
        end
      end
      ST_SETUP:
      begin
        next_st.state = ST_CONVERT;
      end
      ST_CONVERT:
      begin
        if (conv.done)
        begin
          next_st.state = ST_NEXT;
        end
      end
      ST_NEXT:
      begin
        if (step_is_last(st.step, st.fullSeq))
        begin
          next_st.seqDone = 1'b1;
          next_st.seqCount = st.seqCount + 16'h0001;
          // normal mode falls asleep on its own after the measurement
          next_st.state = st.cmdMode ? ST_ACTIVE : ST_SLEEP; // RL2
        end
        else
        begin
          next_st.state = ST_SETUP; // RL5
          next_st.step = bms_step_t'(st.step + 3'b001);
        end
      end
      default:
      begin
        next_st.state = ST_SLEEP;
      end
    endcase

    // mux and analog steering follow the step being set up or converted
    if ((next_st.state == ST_SETUP) || (next_st.state == ST_CONVERT))
    begin
      next_st.autoZero = step_is_az(next_st.step); // RL6
      case (next_st.step)
        STEP_BRIDGE:
        begin
          next_st.muxSel = MUX_BRIDGE; // RL4
          next_st.measKind = KIND_BRIDGE; // RL3
          next_st.chopInv = st.cfg[CFG_POL]; // RL11
        end
        STEP_AZ_TEMP,
        STEP_TEMP:
        begin
          next_st.muxSel = (next_st.step == STEP_TEMP) ? MUX_TEMP : MUX_SHORT; // RL4
          next_st.measKind = KIND_TEMP; // RL3
          next_st.chopInv = 1'b0;
        end
        STEP_OFFSET:
        begin
          next_st.muxSel = MUX_SHORT; // RL4
          next_st.measKind = KIND_OFFSET; // RL3
          next_st.chopInv = 1'b0;
        end
        default:
        begin
          next_st.muxSel = MUX_SHORT; // RL4
          next_st.measKind = KIND_BRIDGE;
          next_st.chopInv = st.cfg[CFG_POL]; // RL11
        end
      endcase
    end
    else
    begin
      next_st.autoZero = 1'b0;
      next_st.chopInv = 1'b0;
      next_st.muxSel = MUX_SHORT;
    end

    // sticky completion flag: a new completion beats a clear in the same cycle
    if (wrStatus && regWrData[STAT_DONE])
    begin
      next_st.doneSticky = 1'b0;
    end
    if (next_st.seqDone)
    begin
      next_st.doneSticky = 1'b1;
    end

    // ----------------------------------------------------------------
    // read data, valid the cycle after the strobe
    // ----------------------------------------------------------------
    next_st.rdData = 32'h0000_0000;
    if (regRd)
    begin
      if (regAddr == OFS_CTRL)
      begin
        next_st.rdData[CTRL_CMD_MODE] = st.cmdMode;
      end
      else if (regAddr == OFS_CONFIG)
      begin
        next_st.rdData[CFG_W-1:0] = st.cfg;
      end
      else if (regAddr == OFS_STATUS)
      begin
        next_st.rdData[STAT_DONE] = st.doneSticky;
        next_st.rdData[STAT_BUSY] = (st.state != ST_SLEEP) && (st.state != ST_ACTIVE);
        next_st.rdData[STAT_ACTIVE] = (st.state != ST_SLEEP);
        next_st.rdData[STAT_KIND_LO +: 2] = st.measKind;
        next_st.rdData[STAT_MUX_LO +: 2] = st.muxSel;
        next_st.rdData[STAT_STATE_LO +: 3] = st.state;
      end
      else if (regAddr == OFS_COUNT)
      begin
        next_st.rdData[15:0] = st.seqCount;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      // the supervisor reset parks everything asleep with a default config
      st <= '0; // RL13 RL17
      st.state <= ST_SLEEP; // RL17
      st.cmdMode <= CMD_MODE_RESET;
      st.cfg <= CFG_RESET;
      st.loadPending <= 1'b1;
      st.muxSel <= MUX_SHORT;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdData = st.rdData;
  assign activeState = (st.state != ST_SLEEP);
  assign muxSel = st.muxSel;
  assign autoZero = st.autoZero;
  assign chopperInvert = st.chopInv;
  assign measKind = st.measKind;
  assign convActive = conv.busy;
  assign first_amp_gain_sel = st.firstGain;
  assign second_amp_gain_sel = st.secondGain;
  assign adcMsbBits = st.msbBits;
  assign adcLsbBits = st.lsbBits;
  assign adcResolution = st.resolution;
  assign seqDone = st.seqDone;

endmodule : bms_sequencer
`default_nettype wire

// ===== bench/bms_sequencer_sva.sv
// port-level assertions for the bridge measurement sequencer
`timescale 1ns/1ps
`default_nettype none
module bms_sequencer_sva
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [bms_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic activeState,
  input wire logic [1:0] muxSel,
  input wire logic autoZero,
  input wire logic chopperInvert,
  input wire logic [1:0] measKind,
  input wire logic convActive,
  input wire logic [5:0] first_amp_gain_sel,
  input wire logic [4:0] second_amp_gain_sel,
  input wire logic [4:0] adcMsbBits,
  input wire logic [2:0] adcLsbBits,
  input wire logic [4:0] adcResolution,
  input wire logic seqDone
);
  import bms_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_ctrl_wr;
    regWr && regAddr == OFS_CTRL;
  endsequence
  sequence s_full_req;
    s_ctrl_wr ##0 (regWrData[CTRL_START_FULL] && !activeState);
  endsequence
  sequence s_az_then_conv;
    ##[1:2] (activeState && autoZero && muxSel == MUX_SHORT) ##[1:3] convActive;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // no disable here: the reset itself is the cause being checked
  chk_reset_sleep: assert property (rst |=> !activeState && !convActive && !autoZero)
    else $error("sequencer not idle after reset");
  chk_full_start: assert property (disable iff (rst) s_full_req |-> s_az_then_conv)
    else $error("full request did not start with bridge auto-zero");
  chk_stay_asleep: assert property (disable iff (rst) s_ctrl_wr ##0 (!regWrData[CTRL_CMD_MODE]
    && !regWrData[CTRL_START_FULL] && !activeState) |=> !activeState)
    else $error("woke without full request or command mode");
  chk_cmd_enter: assert property (disable iff (rst) s_ctrl_wr ##0 (regWrData[CTRL_CMD_MODE]
    && !regWrData[CTRL_START_FULL] && !activeState) |=> ##[0:1] activeState)
    else $error("command mode did not wake the sequencer");
  chk_az_short: assert property (disable iff (rst) autoZero |-> muxSel == MUX_SHORT)
    else $error("auto-zero without shorted input");
  chk_chop_bridge: assert property (disable iff (rst)
    chopperInvert |-> activeState && muxSel != MUX_TEMP)
    else $error("chopper inverted outside bridge steps");
  chk_mux_kind: assert property (disable iff (rst) $past(convActive) && convActive && !autoZero
    |-> muxSel == (measKind == KIND_BRIDGE ? MUX_BRIDGE :
    (measKind == KIND_TEMP ? MUX_TEMP : MUX_SHORT)))
    else $error("input selector does not match measurement kind");
  chk_gain_first: assert property (disable iff (rst) first_amp_gain_sel != 6'h00
    |-> first_amp_gain_sel inside {6'h0c, 6'h14, 6'h1e, 6'h28})
    else $error("illegal first stage gain");
  chk_gain_second: assert property (disable iff (rst) second_amp_gain_sel != 5'h00
    |-> second_amp_gain_sel inside {[5'h0b:5'h12]})
    else $error("illegal second stage gain");
  chk_res_sum: assert property (disable iff (rst) adcResolution == (adcLsbBits == 3'h0 ?
    adcMsbBits : 5'(adcMsbBits + 5'(adcLsbBits) - 5'h01)))
    else $error("resolution does not match segmentation");
  chk_done_pulse: assert property (disable iff (rst) seqDone |=> !seqDone)
    else $error("done pulse longer than one cycle");
endmodule : bms_sequencer_sva
`default_nettype wire

// ===== bench/bms_cal_host_model.sv
// calibration host and nonvolatile store model feeding the configuration word
`timescale 1ns/1ps
`default_nettype none
module bms_cal_host_model
(
  input wire logic [5:0] optFirst,
  input wire logic [2:0] secondSel,
  input wire logic [15:0] vMaxMag,
  input wire logic [15:0] vMinMag,
  input wire logic [1:0] msbSel,
  input wire logic [1:0] lsbSel,
  input wire logic [7:0] ratioQ8,
  output logic [3:0] adc_offset_shift,
  output logic [bms_pkg::CFG_W-1:0] measurement_config_word
);
  import bms_pkg::*;
  logic [1:0] firstSel;
  logic gainInvert;
  logic [4:0] shiftRaw;

  always_comb
  begin
    // largest first stage gain that stays at or below the optimum
    firstSel = optFirst >= 6'h28 ? 2'b11 : (optFirst >= 6'h1e ? 2'b10 :
      (optFirst >= 6'h14 ? 2'b01 : 2'b00));
    gainInvert = (vMaxMag <= vMinMag);
    shiftRaw = 5'(({1'b0, ratioQ8} + 9'h008) >> 4);
    adc_offset_shift = shiftRaw < 5'h01 ? 4'h1 : (shiftRaw > 5'h08 ? 4'h8 : 4'(shiftRaw));
    measurement_config_word = {6'h00, lsbSel, msbSel, gainInvert, secondSel, firstSel};
  end
endmodule : bms_cal_host_model
`default_nettype wire

// ===== bench/tb_bms_sequencer.sv
// self-checking testbench of the bridge measurement sequencer
`timescale 1ns/1ps
`default_nettype none
bind bms_sequencer bms_sequencer_sva bms_sequencer_sva_i (.sys_clk, .rst, .regAddr, .regWrData,
  .regWr, .activeState, .muxSel, .autoZero, .chopperInvert, .measKind, .convActive,
  .first_amp_gain_sel, .second_amp_gain_sel, .adcMsbBits, .adcLsbBits, .adcResolution, .seqDone);
module tb_bms_sequencer;
  import bms_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic [15:0] cfgWord;
  logic activeState, autoZero, chopperInvert, convActive, seqDone;
  logic [1:0] muxSel, measKind;
  logic [1:0] msbSel = 2'h0;
  logic [1:0] lsbSel = 2'h0;
  logic [5:0] firstGain;
  logic [5:0] optFirst = 6'h0c;
  logic [4:0] secondGain, msbBits, resBits;
  logic [2:0] lsbBits;
  logic [2:0] secondSel = 3'h0;
  logic [15:0] vMinMag = 16'h0010;
  int failCount = 0;
  int checked = 0;

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  bms_cal_host_model bms_cal_host_model_i (.optFirst(optFirst), .secondSel(secondSel),
    .vMaxMag(16'h0080), .vMinMag(vMinMag), .msbSel(msbSel), .lsbSel(lsbSel),
    .ratioQ8(8'h30), .adc_offset_shift(), .measurement_config_word(cfgWord));
  bms_sequencer bms_sequencer_i (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .measurement_config_word(cfgWord), .activeState(activeState), .muxSel(muxSel),
    .autoZero(autoZero), .chopperInvert(chopperInvert), .measKind(measKind),
    .convActive(convActive), .first_amp_gain_sel(firstGain), .second_amp_gain_sel(secondGain),
    .adcMsbBits(msbBits), .adcLsbBits(lsbBits), .adcResolution(resBits), .seqDone(seqDone));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= addr;
    regWrData <= data;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] addr, output logic [31:0] data);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= addr;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    data = regRdData;
  endtask : reg_rd

  task automatic do_reset(input int n);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (n) @(posedge sys_clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic results();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    logic [31:0] rd;
    tick(2);
    check("asleep", 32'(activeState), 32'h1 - 32'h1);
    check("idle mux", 32'(muxSel), 32'(MUX_SHORT));
    reg_rd(OFS_CONFIG, rd);
    check("config copy", rd, 32'h0);
  endtask : test_reset

  // every gain, polarity and segmentation code, reloaded from the store model
  task automatic test_decode();
    logic [31:0] rd;
    logic [5:0] optTab [4] = '{6'h0c, 6'h19, 6'h27, 6'h28};
    logic [5:0] gainTab [4] = '{6'h0c, 6'h14, 6'h1e, 6'h28};
    logic [2:0] lsbTab [4] = '{3'h0, 3'h3, 3'h5, 3'h7};
    logic [4:0] msbExp;
    for (int i = 0; i < 32; i++)
    begin
      @(posedge sys_clk);
      optFirst <= optTab[i % 4];
      secondSel <= 3'(i / 4);
      msbSel <= 2'(i % 4);
      lsbSel <= 2'(i / 8);
      vMinMag <= i[0] ? 16'h0080 : 16'h0010;
      reg_wr(OFS_CTRL, 32'h20);
      tick(4);
      msbExp = 5'(10 + 2 * (i % 4));
      check("first gain", 32'(firstGain), 32'(gainTab[i % 4]));
      check("second gain", 32'(secondGain), 32'(11 + i / 4));
      check("msb bits", 32'(msbBits), 32'(msbExp));
      check("lsb bits", 32'(lsbBits), 32'(lsbTab[i / 8]));
      check("resolution", 32'(resBits), lsbTab[i / 8] == 3'h0 ? 32'(msbExp) :
        32'(msbExp) + 32'(lsbTab[i / 8]) - 32'h1);
      reg_rd(OFS_CONFIG, rd);
      check("config word", rd, {22'h0, 2'(i / 8), 2'(i % 4), i[0], 3'(i / 4), 2'(i % 4)});
    end
  endtask : test_decode

  task automatic test_modes();
    logic [31:0] rd;
    reg_wr(OFS_CTRL, 32'h4);
    tick(3);
    check("single ignored asleep", 32'(activeState), 32'h0);
    reg_wr(OFS_CTRL, 32'h1);
    tick(2);
    check("command mode awake", 32'(activeState), 32'h1);
    reg_rd(OFS_CTRL, rd);
    check("command bit", rd & 32'h1, 32'h1);
    reg_rd(8'h10, rd);
    check("unmapped read", rd, 32'h0);
    reg_wr(OFS_CTRL, 32'h0);
    tick(2);
    check("back to sleep", 32'(activeState), 32'h0);
  endtask : test_modes

  // full request, a refused second start, then reset in mid-sequence
  task automatic test_full();
    int n;
    logic [31:0] rd;
    reg_wr(OFS_CTRL, 32'h2);
    tick(2);
    check("full awake", 32'(activeState), 32'h1);
    check("bridge auto-zero", 32'(autoZero), 32'h1);
    check("auto-zero short", 32'(muxSel), 32'(MUX_SHORT));
    check("inverted chopper", 32'(chopperInvert), 32'h1);
    for (n = 0; n < 6 && convActive !== 1'b1; n++)
      tick(1);
    check("conversion running", 32'(convActive), 32'h1);
    // a single offset start would drop auto-zero if it were taken mid-sequence
    reg_wr(OFS_CTRL, 32'h14);
    tick(1);
    check("start refused", 32'(autoZero), 32'h1);
    reg_rd(OFS_STATUS, rd);
    check("status converting", rd, 32'h0000_0346);
    reg_rd(OFS_COUNT, rd);
    check("count idle", rd, 32'h0);
    check("no done yet", 32'(seqDone), 32'h0);
    do_reset(2);
    tick(1);
    check("reset sleeps", 32'(activeState), 32'h0);
    check("reset stops timer", 32'(convActive), 32'h0);
  endtask : test_full

  task automatic test_singles();
    for (int k = 0; k < 3; k++)
    begin
      reg_wr(OFS_CTRL, 32'h1);
      reg_wr(OFS_CTRL, 32'h5 | 32'(k << 3));
      tick(2);
      check("single auto-zero", 32'(autoZero), 32'(k != 2));
      check("single mux", 32'(muxSel), 32'(MUX_SHORT));
      check("single chopper", 32'(chopperInvert), 32'(k == 0));
      if (k == 2)
        check("offset kind", 32'(measKind), 32'(KIND_OFFSET));
      tick(3);
      check("single converts", 32'(convActive), 32'h1);
      do_reset(2);
    end
  endtask : test_singles

  initial
  begin
    #500000;
    failCount++;
    results();
  end

  initial
  begin
    do_reset(8);
    test_reset();
    test_decode();
    test_modes();
    test_full();
    test_singles();
    results();
  end
endmodule : tb_bms_sequencer
`default_nettype wire
